//--- hdl/mdf_pkg.sv
// Notes on behaviour
// - scan 0x0800..0x27FF as aligned 256-byte blocks
// - never touch the special register region
// - stage each block in 24x16 byte cells
// - prepend eight header bytes, giving 264 bytes
// - header starts 0x8B 0xAD 0xF0 0x0D
// - header bytes 5-6: block address, low first
// - header bytes 7-8: frame pointer, low first
// - 24 rows of 11 data bytes each
// - four XOR checksums, distinct subsets, each data byte in two to four of them
// - column 16 is XOR of first fifteen
// - parity may skip triple-covered data bytes
// - transmit column by column, 0,16,...,368,1,...
// - bytes go LSB first, differential Manchester
// - toggle every bit start, mid-bit toggle for one
// - half-bit lasts 2176 instruction cycles
// - pause about 4 ms between blocks
// - loop over memory until device detaches
package mdf_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;

  // memory range and block layout
  localparam logic [15:0] DATA_BASE = 16'h0800;
  localparam logic [15:0] DATA_LAST = 16'h27FF;
  localparam int BLOCK_BYTES = 256;
  localparam int BLOCK_COUNT =
    (int'(DATA_LAST) - int'(DATA_BASE) + 1) / BLOCK_BYTES;
  localparam logic [4:0] LAST_BLOCK = 5'(BLOCK_COUNT - 1);
  localparam int HDR_BYTES = 8;
  localparam int EXT_BYTES = BLOCK_BYTES + HDR_BYTES;

  // staging matrix
  localparam int ROWS = 24;
  localparam int COLS = 16;
  localparam int DATA_COLS = 11;
  localparam int STAGE_CELLS = ROWS * COLS;
  localparam logic [4:0] LAST_ROW = 5'(ROWS - 1);
  localparam logic [3:0] LAST_COL = 4'(COLS - 1);
  localparam logic [3:0] LAST_DATA_COL = 4'(DATA_COLS - 1);
  localparam logic [8:0] HDR_LIMIT = 9'(HDR_BYTES);

  // block start marker
  localparam logic [7:0] MARK0 = 8'h8B;
  localparam logic [7:0] MARK1 = 8'hAD;
  localparam logic [7:0] MARK2 = 8'hF0;
  localparam logic [7:0] MARK3 = 8'h0D;

  // buffering
  localparam int FIFO_DEPTH = 8;

  // timing
  localparam int CLK_KHZ = 125000;
  localparam int INSTR_KHZ = 16000;
  localparam int HALF_BIT_INSTR = 2176;
  localparam int HALF_BIT_CYCLES = HALF_BIT_INSTR * CLK_KHZ / INSTR_KHZ;
  localparam int PAUSE_MS = 4;
  localparam int PAUSE_CYCLES = PAUSE_MS * CLK_KHZ;
  localparam int CNT_W = 20;

  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_WAIT, ST_CAP, ST_ROW, ST_SEND, ST_DRAIN, ST_PAUSE
  } mdf_state_type;

endpackage

//--- hdl/mdf_byte_if.sv
`timescale 1ns/1ps
// byte stream with valid/ready
interface mdf_byte_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

//--- hdl/mdf_fifo.sv
`timescale 1ns/1ps
module mdf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  mdf_byte_if.snk inP,
  mdf_byte_if.src outP
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wrPtr_r;
  logic [PW:0] rdPtr_r;
  logic full;
  logic empty;
  logic doPush;
  logic doPop;

  // occupancy flags from pointer wrap bit
  assign empty = (wrPtr_r == rdPtr_r);
  assign full = (wrPtr_r[PW-1:0] == rdPtr_r[PW-1:0]) &&
                (wrPtr_r[PW] != rdPtr_r[PW]);
  assign inP.ready = !full;
  assign outP.valid = !empty;
  assign outP.data = mem[rdPtr_r[PW-1:0]];
  assign doPush = inP.valid && !full;
  assign doPop = outP.ready && !empty;

  // storage write
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_r[PW-1:0]] <= inP.data;
    end
  end

  // write pointer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= '0;
    end else if (doPush) begin
      wrPtr_r <= wrPtr_r + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdPtr_r <= '0;
    end else if (doPop) begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
endmodule

//--- hdl/mdf_dump_framer.sv
`timescale 1ns/1ps
module mdf_dump_framer
  import mdf_pkg::*;
#(
  parameter int HALF_BIT_CNT = HALF_BIT_CYCLES,
  parameter int PAUSE_CNT = PAUSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic dumpRequest,
  input wire logic deviceAttached,
  input wire logic [15:0] frameWord,
  output logic [15:0] memAddr,
  output logic memRdEn,
  input wire logic [7:0] memRdData,
  output logic lineOut,
  output logic dumpActive
);

  ////////////////////////////////////////////////////////////////////
  // declarations
  mdf_state_type state_r;
  logic [4:0] blockIdx_r;
  logic [4:0] rowIdx_r;
  logic [3:0] colIdx_r;
  logic [8:0] extIdx_r;
  logic [15:0] frameWord_r;
  logic [7:0] rowBuf_r [DATA_COLS];
  logic [7:0] stage_r [STAGE_CELLS];
  logic [4:0] sendRow_r;
  logic [3:0] sendCol_r;
  logic sendDone_r;
  logic [CNT_W-1:0] pauseCnt_r;
  logic [7:0] hdrByte;
  logic [8:0] memOff;
  logic [7:0] blockHi;
  logic [7:0] ck0;
  logic [7:0] ck1;
  logic [7:0] ck2;
  logic [7:0] ck3;
  logic [7:0] parity;
  logic coderBusy_r;
  logic [7:0] shift_r;
  logic [2:0] bitIdx_r;
  logic midPhase_r;
  logic [CNT_W-1:0] halfCnt_r;
  logic halfEnd;
  logic byteEnd;
  logic loadByte;

  mdf_byte_if pushIf ();
  mdf_byte_if popIf ();

  ////////////////////////////////////////////////////////////////////
  // byte buffer between matrix reader and line coder
  mdf_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .reset_n(reset_n),
    .inP(pushIf.snk),
    .outP(popIf.src)
  );

  ////////////////////////////////////////////////////////////////////
  // header and address generation
  // block base high byte, low byte always zero
  assign blockHi = 8'(DATA_BASE[15:8] + {3'h0, blockIdx_r});
  assign memOff = 9'(extIdx_r - HDR_LIMIT);

  // header bytes in emit order
  always_comb begin
    unique case (extIdx_r[2:0])
      3'h0: hdrByte = MARK0;
      3'h1: hdrByte = MARK1;
      3'h2: hdrByte = MARK2;
      3'h3: hdrByte = MARK3;
      3'h4: hdrByte = DATA_BASE[7:0];
      3'h5: hdrByte = blockHi;
      3'h6: hdrByte = frameWord_r[7:0];
      3'h7: hdrByte = frameWord_r[15:8];
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // row checksums over the eleven data cells
  assign ck0 = rowBuf_r[0] ^ rowBuf_r[1] ^ rowBuf_r[3] ^ rowBuf_r[4] ^
               rowBuf_r[6] ^ rowBuf_r[8] ^ rowBuf_r[10];
  assign ck1 = rowBuf_r[0] ^ rowBuf_r[2] ^ rowBuf_r[3] ^ rowBuf_r[5] ^
               rowBuf_r[6] ^ rowBuf_r[9] ^ rowBuf_r[10];
  assign ck2 = rowBuf_r[1] ^ rowBuf_r[2] ^ rowBuf_r[3] ^ rowBuf_r[7] ^
               rowBuf_r[8] ^ rowBuf_r[9] ^ rowBuf_r[10];
  assign ck3 = rowBuf_r[4] ^ rowBuf_r[5] ^ rowBuf_r[6] ^ rowBuf_r[7] ^
               rowBuf_r[8] ^ rowBuf_r[9] ^ rowBuf_r[10];
  // reduced form, equals XOR of all fifteen preceding cells
  assign parity = rowBuf_r[0] ^ rowBuf_r[1] ^ rowBuf_r[2] ^ rowBuf_r[4] ^
                  rowBuf_r[5] ^ rowBuf_r[7] ^ rowBuf_r[10];

  ////////////////////////////////////////////////////////////////////
  // block sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (dumpRequest && deviceAttached) begin
            state_r <= ST_REQ;
          end
        end
        ST_REQ: state_r <= ST_WAIT;
        ST_WAIT: state_r <= ST_CAP;
        ST_CAP: begin
          if (colIdx_r == LAST_DATA_COL) begin
            state_r <= ST_ROW;
          end else begin
            state_r <= ST_REQ;
          end
        end
        ST_ROW: begin
          if (rowIdx_r == LAST_ROW) begin
            state_r <= ST_SEND;
          end else begin
            state_r <= ST_REQ;
          end
        end
        ST_SEND: begin
          if (sendDone_r) begin
            state_r <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (!popIf.valid && !coderBusy_r) begin
            state_r <= ST_PAUSE;
          end
        end
        ST_PAUSE: begin
          if (pauseCnt_r == CNT_W'(PAUSE_CNT - 1)) begin
            if (deviceAttached) begin
              state_r <= ST_REQ;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // block counter wraps over the whole range
  // detach is only looked at here, so a block is never cut short
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blockIdx_r <= '0;
    end else if (state_r == ST_IDLE) begin
      blockIdx_r <= '0;
    end else if (state_r == ST_PAUSE &&
                 pauseCnt_r == CNT_W'(PAUSE_CNT - 1)) begin
      if (blockIdx_r == LAST_BLOCK) begin
        blockIdx_r <= '0;
      end else begin
        blockIdx_r <= blockIdx_r + 5'h1;
      end
    end
  end

  // frame pointer sampled as a block begins; it follows the input while
  // idle or pausing and freezes once the fill starts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frameWord_r <= '0;
    end else if ((state_r == ST_IDLE || state_r == ST_PAUSE) &&
                 extIdx_r == 9'h000) begin
      frameWord_r <= frameWord;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fill: fetch 264 extended bytes row by row
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extIdx_r <= '0;
      colIdx_r <= '0;
      rowIdx_r <= '0;
    end else begin
      if (state_r == ST_IDLE || state_r == ST_PAUSE) begin
        extIdx_r <= '0;
        colIdx_r <= '0;
        rowIdx_r <= '0;
      end else if (state_r == ST_CAP) begin
        extIdx_r <= extIdx_r + 9'h001;
        if (colIdx_r != LAST_DATA_COL) begin
          colIdx_r <= colIdx_r + 4'h1;
        end
      end else if (state_r == ST_ROW) begin
        colIdx_r <= '0;
        rowIdx_r <= rowIdx_r + 5'h1;
      end
    end
  end

  // memory read port, only inside the plain data range
  // addresses never leave the block window, so no register space is hit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      memAddr <= DATA_BASE;
      memRdEn <= 1'b0;
    end else begin
      memRdEn <= 1'b0;
      if (state_r == ST_REQ && extIdx_r >= HDR_LIMIT) begin
        memAddr <= {blockHi, memOff[7:0]};
        memRdEn <= 1'b1;
      end
    end
  end

  // capture header or memory byte into the row
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DATA_COLS; i++) begin
        rowBuf_r[i] <= '0;
      end
    end else if (state_r == ST_CAP) begin
      if (extIdx_r < HDR_LIMIT) begin
        rowBuf_r[colIdx_r] <= hdrByte;
      end else begin
        rowBuf_r[colIdx_r] <= memRdData;
      end
    end
  end

  // write one finished row into the staging matrix
  always_ff @(posedge clk) begin
    if (state_r == ST_ROW) begin
      for (int k = 0; k < DATA_COLS; k++) begin
        stage_r[{rowIdx_r, 4'(k)}] <= rowBuf_r[k];
      end
      stage_r[{rowIdx_r, 4'hB}] <= ck0;
      stage_r[{rowIdx_r, 4'hC}] <= ck1;
      stage_r[{rowIdx_r, 4'hD}] <= ck2;
      stage_r[{rowIdx_r, 4'hE}] <= ck3;
      stage_r[{rowIdx_r, 4'hF}] <= parity;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transposed readout into the buffer
  assign pushIf.valid = (state_r == ST_SEND) && !sendDone_r;
  assign pushIf.data = stage_r[{sendRow_r, sendCol_r}];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sendRow_r <= '0;
      sendCol_r <= '0;
      sendDone_r <= 1'b0;
    end else if (state_r != ST_SEND) begin
      sendRow_r <= '0;
      sendCol_r <= '0;
      sendDone_r <= 1'b0;
    end else if (pushIf.valid && pushIf.ready) begin
      if (sendRow_r == LAST_ROW) begin
        sendRow_r <= '0;
        if (sendCol_r == LAST_COL) begin
          sendDone_r <= 1'b1;
        end else begin
          sendCol_r <= sendCol_r + 4'h1;
        end
      end else begin
        sendRow_r <= sendRow_r + 5'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // inter-block pause
  // next block is staged after this, so the line stays quiet longer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pauseCnt_r <= '0;
    end else if (state_r == ST_PAUSE) begin
      pauseCnt_r <= pauseCnt_r + 1'b1;
    end else begin
      pauseCnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // differential Manchester line coder
  // only toggles carry data, so an inverted capture decodes the same
  assign halfEnd = coderBusy_r && (halfCnt_r == CNT_W'(HALF_BIT_CNT - 1));
  assign byteEnd = halfEnd && midPhase_r && (bitIdx_r == 3'h7);
  assign loadByte = popIf.valid && (!coderBusy_r || byteEnd);
  assign popIf.ready = !coderBusy_r || byteEnd;

  // half-bit timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      halfCnt_r <= '0;
    end else if (loadByte || halfEnd || !coderBusy_r) begin
      halfCnt_r <= '0;
    end else begin
      halfCnt_r <= halfCnt_r + 1'b1;
    end
  end

  // bit and phase tracking
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coderBusy_r <= 1'b0;
      shift_r <= '0;
      bitIdx_r <= '0;
      midPhase_r <= 1'b0;
    end else if (loadByte) begin
      coderBusy_r <= 1'b1;
      shift_r <= popIf.data;
      bitIdx_r <= '0;
      midPhase_r <= 1'b0;
    end else if (byteEnd) begin
      coderBusy_r <= 1'b0;
    end else if (halfEnd) begin
      midPhase_r <= !midPhase_r;
      if (midPhase_r) begin
        bitIdx_r <= bitIdx_r + 3'h1;
        shift_r <= {1'b0, shift_r[7:1]};
      end
    end
  end

  // output level toggles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lineOut <= 1'b0;
    end else if (loadByte) begin
      lineOut <= !lineOut;
    end else if (halfEnd && !byteEnd) begin
      if (midPhase_r) begin
        lineOut <= !lineOut;
      end else if (shift_r[0]) begin
        lineOut <= !lineOut;
      end
    end
  end

  assign dumpActive = (state_r != ST_IDLE);

endmodule

//--- test/mdf_dump_framer_asserts.sv
`timescale 1ns/1ps
// port checker for the dump framer
module mdf_dump_framer_asserts
  import mdf_pkg::*;
#(
  parameter int HALF_BIT_CNT = HALF_BIT_CYCLES,
  parameter int PAUSE_CNT = PAUSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic dumpRequest,
  input wire logic deviceAttached,
  input wire logic [15:0] frameWord,
  input wire logic [15:0] memAddr,
  input wire logic memRdEn,
  input wire logic [7:0] memRdData,
  input wire logic lineOut,
  input wire logic dumpActive
);
  logic [15:0] lastAddr_r;
  logic seenRd_r;
  logic [7:0] rdCnt_r;
  logic lastLine_r;
  int gapCnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // last read address and reads so far
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastAddr_r <= DATA_BASE;
      seenRd_r <= 1'b0;
      rdCnt_r <= 8'h00;
    end else if (memRdEn) begin
      lastAddr_r <= memAddr;
      seenRd_r <= 1'b1;
      rdCnt_r <= rdCnt_r + 8'h01;
    end else if (!dumpActive) begin
      seenRd_r <= 1'b0; // a new dump starts again at the base
      rdCnt_r <= 8'h00;
    end
  end
  // cycles since the line last changed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastLine_r <= 1'b0;
      gapCnt_r <= 32'h000F_FFFF;
    end else begin
      lastLine_r <= lineOut;
      gapCnt_r <= (lineOut != lastLine_r) ? 1 : gapCnt_r + 1;
    end
  end
  ////////////////////////////////////////
  chk_read_pulse:
    assert property (memRdEn |=> !memRdEn [*2])
    else $error("read strobe too long or too close");
  chk_addr_range:
    assert property (memRdEn |-> memAddr >= DATA_BASE && memAddr <= DATA_LAST)
    else $error("read outside plain memory");
  chk_addr_ascend:
    assert property (memRdEn && seenRd_r |-> memAddr == lastAddr_r + 16'h0001
      || (lastAddr_r == DATA_LAST && memAddr == DATA_BASE))
    else $error("read address out of order");
  chk_block_align:
    assert property (memRdEn |-> memAddr[7:0] == rdCnt_r)
    else $error("block reads not aligned");
  chk_read_active:
    assert property (memRdEn |-> dumpActive)
    else $error("read while idle");
  chk_half_bit_gap:
    assert property (lineOut != lastLine_r |-> gapCnt_r == HALF_BIT_CNT
      || gapCnt_r == 2 * HALF_BIT_CNT || gapCnt_r > PAUSE_CNT)
    else $error("line toggle off the half-bit grid");
  chk_idle_quiet:
    assert property (!dumpActive |-> $stable(lineOut))
    else $error("line moved while idle");
  chk_start_cause:
    assert property ($rose(dumpActive) |-> $past(dumpRequest)
      && $past(deviceAttached))
    else $error("dump started without request");
  chk_stop_cause:
    assert property ($fell(dumpActive) |-> !$past(deviceAttached))
    else $error("dump stopped while attached");
  cov_start: cover property ($rose(dumpActive));
  cov_block_end: cover property (memRdEn && memAddr == 16'h08FF);
  cov_stop: cover property ($fell(dumpActive));
endmodule

bind mdf_dump_framer mdf_dump_framer_asserts #(
  .HALF_BIT_CNT(HALF_BIT_CNT), .PAUSE_CNT(PAUSE_CNT)
) u_chk (
  .clk(clk), .reset_n(reset_n), .dumpRequest(dumpRequest),
  .deviceAttached(deviceAttached), .frameWord(frameWord),
  .memAddr(memAddr), .memRdEn(memRdEn), .memRdData(memRdData),
  .lineOut(lineOut), .dumpActive(dumpActive)
);

//--- test/mdf_line_recorder.sv
`timescale 1ns/1ps
// recorder: decodes the serial level by toggle timing
module mdf_line_recorder #(
  parameter int HALF_BIT_CNT = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic lineOut
);
  logic [7:0] rxQ[$];
  int errCnt = 0;
  logic prevLvl;
  logic busy;
  logic midSeen;
  logic [7:0] sh;
  int cnt;
  int nBits;
  // strict grid: toggles only at half or whole bit
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy = 1'b0;
      prevLvl = lineOut;
    end else begin
      if (busy) cnt++;
      if (!busy && lineOut != prevLvl) begin
        busy = 1'b1;
        cnt = 0;
        nBits = 0;
      end else if (busy && cnt == HALF_BIT_CNT) begin
        midSeen = lineOut != prevLvl;
      end else if (busy && cnt == 2 * HALF_BIT_CNT) begin
        sh = {midSeen, sh[7:1]};
        nBits++;
        cnt = 0;
        if (nBits == 8) begin
          rxQ.push_back(sh);
          nBits = 0;
        end
        if (lineOut == prevLvl) begin
          busy = 1'b0;
          if (nBits != 0) errCnt++;
        end
      end else if (lineOut != prevLvl) begin
        errCnt++;
      end
      prevLvl = lineOut;
    end
  end
endmodule

//--- test/tb_memory_dump_secded_framer.sv
`timescale 1ns/1ps
// bench: two blocks checked cell by cell off the wire
module tb_memory_dump_secded_framer;
  import mdf_pkg::*;
  localparam int HB = 4;
  localparam int PC = 10;
  localparam logic [10:0] MASK [4] = '{11'h55B, 11'h66D, 11'h78E, 11'h7F0};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic dumpRequest = 1'b0;
  logic deviceAttached = 1'b1;
  logic [15:0] frameWord = 16'hA5C3;
  logic [15:0] memAddr;
  logic memRdEn;
  logic [7:0] memRdData = 8'h00;
  logic lineOut;
  logic dumpActive;
  logic [15:0] expAddr = 16'h0800;
  int failures = 0;
  int checks = 0;

  mdf_dump_framer #(.HALF_BIT_CNT(HB), .PAUSE_CNT(PC)) u_dut (
    .clk(clk), .reset_n(reset_n), .dumpRequest(dumpRequest),
    .deviceAttached(deviceAttached), .frameWord(frameWord),
    .memAddr(memAddr), .memRdEn(memRdEn), .memRdData(memRdData),
    .lineOut(lineOut), .dumpActive(dumpActive)
  );
  mdf_line_recorder #(.HALF_BIT_CNT(HB)) u_rec (
    .clk(clk), .reset_n(reset_n), .lineOut(lineOut)
  );
  // clock
  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [7:0] memByte(input logic [15:0] a);
    return 8'(a * 16'h0025) ^ a[15:8];
  endfunction
  task automatic check(input logic [15:0] g, e, input string what);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // memory: data in the cycle after the strobe, scrambled otherwise
  always @(posedge clk) begin
    if (memRdEn) begin
      check(memAddr, expAddr, "read address");
      expAddr <= expAddr + 16'h0001;
    end
    memRdData <= #1 (memRdEn ? memByte(memAddr) : ~memRdData);
  end
  task automatic waitBytes(input int n);
    int i;
    for (i = 0; i < 60000 && u_rec.rxQ.size() < n; i++) begin
      tick(1);
    end
    if (u_rec.rxQ.size() < n) begin
      failures++;
      $display("unexpected at %0t: no block on the line", $time);
      conclude();
    end
  endtask
  // receiver decode of one code word: -1 clean, 0..15 the bit to
  // flip back, 16 an uncorrectable double error
  function automatic int locate(input logic [15:0] w);
    logic [3:0] s;
    logic [3:0] c;
    int k;
    s = w[14:11];
    for (k = 0; k < 11; k++) begin
      if (w[k]) s ^= {MASK[3][k], MASK[2][k], MASK[1][k], MASK[0][k]};
    end
    if (!(^w)) return (s == 4'h0) ? -1 : 16;
    if (s == 4'h0) return 15;
    for (k = 0; k < 15; k++) begin
      if (k < 11) begin
        c = {MASK[3][k], MASK[2][k], MASK[1][k], MASK[0][k]};
      end else begin
        c = 4'(1 << (k - 11));
      end
      if (c == s) return k;
    end
    return 16;
  endfunction
  // rebuild the staged matrix and compare every cell
  task automatic checkBlock(input logic [15:0] base, fp);
    logic [7:0] ext[264];
    logic [7:0] got[384];
    logic [7:0] e[16];
    logic [63:0] hdr;
    logic [15:0] w;
    int k;
    int r;
    int c;
    waitBytes(384);
    hdr = {fp, base, 8'h0D, 8'hF0, 8'hAD, 8'h8B};
    for (k = 0; k < 8; k++) begin
      ext[k] = hdr[8 * k +: 8];
    end
    for (k = 0; k < 256; k++) begin
      ext[8 + k] = memByte(base + 16'(k));
    end
    for (k = 0; k < 384; k++) begin
      got[(k % 24) * 16 + k / 24] = u_rec.rxQ.pop_front();
    end
    for (r = 0; r < 24; r++) begin
      e[15] = 8'h00;
      for (c = 0; c < 15; c++) begin
        e[c] = (c < 11) ? ext[r * 11 + c] : 8'h00;
        for (k = 0; k < 11 && c > 10; k++) begin
          if (MASK[c - 11][k]) e[c] ^= e[k];
        end
        e[15] ^= e[c];
      end
      for (c = 0; c < 16; c++) begin
        check({8'h00, got[r * 16 + c]}, {8'h00, e[c]}, "cell");
      end
      // receiver decode on one bit column of this row
      for (c = 0; c < 16; c++) begin
        w[c] = got[r * 16 + c][r % 8];
      end
      k = r % 16;
      check(16'(locate(w)), 16'hFFFF, "clean word");
      check(16'(locate(w ^ (16'h0001 << k))), 16'(k), "one flip");
      w ^= 16'h0003 << (k % 15);
      check(16'(locate(w)), 16'h0010, "two flips");
    end
  endtask
  ////////////////////////////////////////
  task automatic testReset();
    check(memAddr, 16'h0800, "reset address");
    check({14'h0000, memRdEn, lineOut}, 16'h0000, "reset outputs");
    reset_n = 1'b1;
    tick(3);
    check({15'h0000, dumpActive}, 16'h0000, "idle without request");
    $display("test reset done");
  endtask
  task automatic testFirstBlock();
    dumpRequest = 1'b1;
    tick(2);
    check({15'h0000, dumpActive}, 16'h0001, "dump started");
    dumpRequest = 1'b0;
    tick(20);
    frameWord = 16'h3C5A;
    checkBlock(16'h0800, 16'hA5C3);
    $display("test first block done");
  endtask
  task automatic testDetach();
    int i;
    waitBytes(1);
    deviceAttached = 1'b0;
    checkBlock(16'h0900, 16'h3C5A);
    for (i = 0; i < 200 && dumpActive !== 1'b0; i++) begin
      tick(1);
    end
    check({15'h0000, dumpActive}, 16'h0000, "dump stopped");
    check({15'h0000, i >= PC}, 16'h0001, "pause length");
    tick(100);
    check(16'(u_rec.rxQ.size()), 16'h0000, "bytes after stop");
    check(16'(u_rec.errCnt), 16'h0000, "line coding");
    $display("test detach done");
  endtask
  // main sequence
  initial begin
    tick(10);
    testReset();
    testFirstBlock();
    testDetach();
    conclude();
  end
endmodule
